// ==== core/isu_regs.svh ====
// Register offsets, field positions and reset values of the interrupt status/mask unit
`ifndef ISU_REGS_SVH
`define ISU_REGS_SVH
`define ISU_AW            18
`define ISU_NUM_WORDS     22
`define ISU_NUM_PINS      8
`define ISU_SIG_DET_ADDR  18'h1_80a0
`define ISU_FREQ_ADDR     18'h1_80a4
`define ISU_FAULT_ADDR    18'h1_80a8
`define ISU_SOFT_ADDR     18'h1_80b0
`define ISU_PIN_ADDR      18'h1_80b8
`define ISU_LOG_ADDR      18'h1_80bc
`define ISU_FLAG_BASE     18'h1_8010
`define ISU_MASK_BASE     18'h1_8110
`define ISU_TRIG_ADDR     18'h1_8238
`define ISU_US_B_BIT      24
`define ISU_US_A_BIT      22
`define ISU_INPUT_BIT     20
`define ISU_COMP_B_BIT    18
`define ISU_COMP_A_BIT    16
`define ISU_REF_LOST_BIT  8
`define ISU_LOCK_BIT      0
`define ISU_WDT_BIT       20
`define ISU_SYS_ERR_BIT   18
`define ISU_PACK_ERR_BIT  17
`define ISU_NMI_BIT       16
`define ISU_PIN_LSB       16
`define ISU_LOG_FULL_BIT  16
`define ISU_TRIG_LSB      16
`define ISU_PIN_WORD      10
`define ISU_BOOT_WORD     1
`define ISU_BOOT_BIT      3
`define ISU_MASK_RESET    32'hffff_ffff
`endif

// ==== core/isu_pkg.sv ====
// Types shared by the interrupt status/mask unit
`include "isu_regs.svh"
package isu_pkg;
  // Live conditions reported by the status registers
  typedef struct packed {
    logic       ultrasonic_b_detect_flag;
    logic       ultrasonic_a_detect_flag;
    logic       input_path_detect_flag;
    logic       compressor_b_detect_flag;
    logic       compressor_a_detect_flag;
    logic       loop_reference_gone_flag;
    logic       loop_locked_flag;
    logic       dsp_watchdog_expired_flag;
    logic       dsp_bus_system_fault_flag;
    logic       dsp_bus_packing_fault_flag;
    logic       dsp_nonmaskable_flag;
    logic [3:0] dsp_soft_irq_flag;
    logic       event_log_full_flag;
  } isu_status_s;

  typedef logic [`ISU_NUM_WORDS-1:0][31:0] isu_bank_t;

  // Whole state of the unit
  typedef struct packed {
    isu_bank_t                   event_mask_bit;
    isu_bank_t                   latched_event_flag;
    isu_bank_t                   src_prev;
    logic [15:0]                 trig;
    logic [2:0][`ISU_NUM_PINS-1:0] sync;
    logic [`ISU_NUM_PINS-1:0]    lvl;
    logic [31:0]                 rdata;
    logic                        irq;
  } isu_state_s;
endpackage

// ==== core/isu_top.sv ====
// Interrupt status, mask and trigger-type unit with latched event flags
`include "isu_regs.svh"
// Notes on behaviour
// - Live signal-detect bits for five detectors
// - Loop reference-lost status at bit 8
// - Loop locked status at bit 0
// - DSP watchdog expired status at bit 20
// - DSP bus fault status bits 18, 17
// - DSP non-maskable status at bit 16
// - Four DSP soft interrupt bits 3..0
// - Pin levels on even bits 16..30
// - Pin level valid only for GPIO inputs
// - Event log FIFO full live status
// - One mask bit per event flag
// - Mask 1 excludes event from request
// - Masks reset to 1, boot event 0
// - Rise/fall trigger types, reset level-triggered
// - Generic flags set on rising edge, pin flags by trigger type, latched
module isu_top (
  input  wire logic                     MCLK_I,
  input  wire logic                     RST_I,
  input  wire logic [`ISU_AW-1:0]       REG_ADDR_I,
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  input  wire logic [31:0]              REG_WDATA_I,
  output logic      [31:0]              REG_RDATA_O,
  input  wire isu_pkg::isu_status_s     STATUS_I,
  input  wire isu_pkg::isu_bank_t       EVT_SRC_I,
  input  wire logic [`ISU_NUM_PINS-1:0] GPIO_PIN_I,
  input  wire logic [`ISU_NUM_PINS-1:0] GPIO_IS_INPUT_I,
  output logic                          IRQ_O
);
  import isu_pkg::*;

  localparam int NW = `ISU_NUM_WORDS;
  localparam int NP = `ISU_NUM_PINS;

  isu_state_s            s_q;
  isu_state_s            s_d;
  isu_bank_t             set_v;
  isu_bank_t             clr_v;
  logic                  wr_flag;
  logic                  wr_mask;
  logic [4:0]            widx;

  // Bank hit: word-aligned and inside the 22-word range
  function automatic logic in_bank(input logic [`ISU_AW-1:0] a,
                                   input logic [`ISU_AW-1:0] base);
    logic [`ISU_AW-1:0] off;
    off = a - base;
    in_bank = (a >= base) && (off[1:0] == 2'b00) && (off[`ISU_AW-1:2] < NW);
  endfunction

  // Word index inside a bank
  function automatic logic [4:0] bank_idx(input logic [`ISU_AW-1:0] a,
                                          input logic [`ISU_AW-1:0] base);
    logic [`ISU_AW-1:0] off;
    off = a - base;
    bank_idx = off[6:2];
  endfunction

  // Decode of the banked write targets
  assign wr_flag = REG_WR_I && in_bank(REG_ADDR_I, `ISU_FLAG_BASE);
  assign wr_mask = REG_WR_I && in_bank(REG_ADDR_I, `ISU_MASK_BASE);
  assign widx    = wr_flag ? bank_idx(REG_ADDR_I, `ISU_FLAG_BASE)
                           : bank_idx(REG_ADDR_I, `ISU_MASK_BASE);

  // Next-state logic for the whole unit
  always_comb begin
    logic [31:0] rd;
    logic        rise_ev;
    logic        fall_ev;
    logic        any;
    rd      = '0;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    any     = 1'b0;
    s_d     = s_q;
    set_v   = '0;
    clr_v   = '0;

    // Pin synchroniser; a level counts once stages two and three agree
    s_d.sync = {s_q.sync[1:0], GPIO_PIN_I};
    for (int k = 0; k < NP; k++) begin
      if (s_q.sync[1][k] == s_q.sync[2][k]) begin
        s_d.lvl[k] = s_q.sync[2][k];
      end
    end

    // Generic sources: flag on rising edge of the condition
    s_d.src_prev = EVT_SRC_I;
    for (int w = 0; w < NW; w++) begin
      set_v[w] = EVT_SRC_I[w] & ~s_q.src_prev[w];
    end

    // Pin events replace the generic sources in bits 31..16 of the pin word
    for (int k = 0; k < NP; k++) begin
      rise_ev = s_q.trig[2*k]   ? (s_d.lvl[k] & ~s_q.lvl[k]) : s_d.lvl[k];
      fall_ev = s_q.trig[2*k+1] ? (~s_d.lvl[k] & s_q.lvl[k]) : ~s_d.lvl[k];
      set_v[`ISU_PIN_WORD][`ISU_TRIG_LSB+2*k]   = rise_ev;
      set_v[`ISU_PIN_WORD][`ISU_TRIG_LSB+2*k+1] = fall_ev;
    end

    // Write-one-to-clear; a set in the same cycle wins
    if (wr_flag) begin
      clr_v[widx] = REG_WDATA_I;
    end
    s_d.latched_event_flag = (s_q.latched_event_flag & ~clr_v) | set_v;

    // Mask and trigger-type writes
    if (wr_mask) begin
      s_d.event_mask_bit[widx] = REG_WDATA_I;
    end
    if (REG_WR_I && (REG_ADDR_I == `ISU_TRIG_ADDR)) begin
      s_d.trig = REG_WDATA_I[31:`ISU_TRIG_LSB];
    end

    // Read mux; status words are sampled live, nothing latches on read
    case (REG_ADDR_I)
      `ISU_SIG_DET_ADDR: begin
        rd[`ISU_US_B_BIT]   = STATUS_I.ultrasonic_b_detect_flag;
        rd[`ISU_US_A_BIT]   = STATUS_I.ultrasonic_a_detect_flag;
        rd[`ISU_INPUT_BIT]  = STATUS_I.input_path_detect_flag;
        rd[`ISU_COMP_B_BIT] = STATUS_I.compressor_b_detect_flag;
        rd[`ISU_COMP_A_BIT] = STATUS_I.compressor_a_detect_flag;
      end
      `ISU_FREQ_ADDR: begin
        rd[`ISU_REF_LOST_BIT] = STATUS_I.loop_reference_gone_flag;
        rd[`ISU_LOCK_BIT]     = STATUS_I.loop_locked_flag;
      end
      `ISU_FAULT_ADDR: begin
        rd[`ISU_WDT_BIT]      = STATUS_I.dsp_watchdog_expired_flag;
        rd[`ISU_SYS_ERR_BIT]  = STATUS_I.dsp_bus_system_fault_flag;
        rd[`ISU_PACK_ERR_BIT] = STATUS_I.dsp_bus_packing_fault_flag;
        rd[`ISU_NMI_BIT]      = STATUS_I.dsp_nonmaskable_flag;
      end
      `ISU_SOFT_ADDR: begin
        rd[3:0] = STATUS_I.dsp_soft_irq_flag;
      end
      `ISU_PIN_ADDR: begin
        // Pins not set up as plain inputs read 0, their level is not meaningful
        for (int k = 0; k < NP; k++) begin
          rd[`ISU_PIN_LSB+2*k] = s_q.lvl[k] & GPIO_IS_INPUT_I[k];
        end
      end
      `ISU_LOG_ADDR: begin
        rd[`ISU_LOG_FULL_BIT] = STATUS_I.event_log_full_flag;
      end
      `ISU_TRIG_ADDR: begin
        rd[31:`ISU_TRIG_LSB] = s_q.trig;
      end
      default: begin
        if (in_bank(REG_ADDR_I, `ISU_FLAG_BASE)) begin
          rd = s_q.latched_event_flag[bank_idx(REG_ADDR_I, `ISU_FLAG_BASE)];
        end else if (in_bank(REG_ADDR_I, `ISU_MASK_BASE)) begin
          rd = s_q.event_mask_bit[bank_idx(REG_ADDR_I, `ISU_MASK_BASE)];
        end else begin
          rd = '0;
        end
      end
    endcase
    if (REG_RD_I) begin
      s_d.rdata = rd;
    end

    // Request from next-state values so it tracks flags with no extra lag
    for (int w = 0; w < NW; w++) begin
      any = any | (|(s_d.latched_event_flag[w] & ~s_d.event_mask_bit[w]));
    end
    s_d.irq = any;
  end

  // State register; masks default to masked except the boot event
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      s_q                                             <= '0;
      s_q.event_mask_bit                              <= {NW{`ISU_MASK_RESET}};
      s_q.event_mask_bit[`ISU_BOOT_WORD][`ISU_BOOT_BIT] <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA_O = s_q.rdata;
  assign IRQ_O       = s_q.irq;

  // Checks on the unit
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  property p_irq_tracks;
    IRQ_O == (|(s_q.latched_event_flag & ~s_q.event_mask_bit));
  endproperty
  a_irq_tracks: assert property (p_irq_tracks)
    else $error("request does not match unmasked flags");

  property p_mask_blocks;
    (s_q.event_mask_bit == {NW{`ISU_MASK_RESET}}) |-> !IRQ_O;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("request raised with every event masked");

  property p_mask_reset;
    $past(RST_I) |->
      s_q.event_mask_bit[`ISU_BOOT_WORD][`ISU_BOOT_BIT] == 1'b0 &&
      s_q.event_mask_bit[0] == `ISU_MASK_RESET &&
      s_q.event_mask_bit[NW-1] == `ISU_MASK_RESET;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask reset values wrong");

  property p_trig_reset;
    $past(RST_I) |-> (s_q.trig == 16'h0000) && !IRQ_O;
  endproperty
  a_trig_reset: assert property (p_trig_reset)
    else $error("trigger types not level after reset");

  property p_edge_sets;
    (|set_v) |=> (($past(set_v) & ~s_q.latched_event_flag) == '0);
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge did not set its flag");

  property p_flag_holds;
    !wr_flag |=> (($past(s_q.latched_event_flag) & ~s_q.latched_event_flag) == '0);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag dropped without a clear");

  property p_mask_write;
    wr_mask |=> s_q.event_mask_bit[$past(widx)] == $past(REG_WDATA_I);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_freq_read;
    REG_RD_I && (REG_ADDR_I == `ISU_FREQ_ADDR) |=>
      REG_RDATA_O[`ISU_LOCK_BIT] == $past(STATUS_I.loop_locked_flag) &&
      REG_RDATA_O[`ISU_REF_LOST_BIT] == $past(STATUS_I.loop_reference_gone_flag);
  endproperty
  a_freq_read: assert property (p_freq_read)
    else $error("loop status read wrong");

  property p_fault_read;
    REG_RD_I && (REG_ADDR_I == `ISU_FAULT_ADDR) |=>
      REG_RDATA_O[`ISU_WDT_BIT] == $past(STATUS_I.dsp_watchdog_expired_flag) &&
      REG_RDATA_O[`ISU_NMI_BIT] == $past(STATUS_I.dsp_nonmaskable_flag);
  endproperty
  a_fault_read: assert property (p_fault_read)
    else $error("dsp fault status read wrong");

  property p_pin_read;
    REG_RD_I && (REG_ADDR_I == `ISU_PIN_ADDR) |=>
      REG_RDATA_O[`ISU_PIN_LSB] == $past(s_q.lvl[0] & GPIO_IS_INPUT_I[0]) &&
      REG_RDATA_O[15:0] == 16'h0000;
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin level read wrong");

  property p_read_quiet;
    REG_RD_I && !REG_WR_I |=>
      (($past(s_q.latched_event_flag) & ~s_q.latched_event_flag) == '0) &&
      s_q.event_mask_bit == $past(s_q.event_mask_bit);
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("read disturbed flags or masks");

  property p_pin_rise;
    $rose(s_q.lvl[0]) |-> s_q.latched_event_flag[`ISU_PIN_WORD][`ISU_TRIG_LSB];
  endproperty
  a_pin_rise: assert property (p_pin_rise)
    else $error("pin rise did not set its flag");

  // Signal-detect word mirrors the five detectors, other bits stay 0
  property p_sigdet_read;
    REG_RD_I && (REG_ADDR_I == `ISU_SIG_DET_ADDR) |=>
      REG_RDATA_O[`ISU_US_B_BIT] == $past(STATUS_I.ultrasonic_b_detect_flag) &&
      REG_RDATA_O[`ISU_US_A_BIT] == $past(STATUS_I.ultrasonic_a_detect_flag) &&
      REG_RDATA_O[`ISU_INPUT_BIT] == $past(STATUS_I.input_path_detect_flag) &&
      REG_RDATA_O[`ISU_COMP_B_BIT] == $past(STATUS_I.compressor_b_detect_flag) &&
      REG_RDATA_O[`ISU_COMP_A_BIT] == $past(STATUS_I.compressor_a_detect_flag) &&
      (REG_RDATA_O & 32'hfeaa_ffff) == 32'h0000_0000;
  endproperty
  a_sigdet_read: assert property (p_sigdet_read)
    else $error("signal-detect status read wrong");

  // Both bus fault bits track their live conditions
  property p_bus_fault_read;
    REG_RD_I && (REG_ADDR_I == `ISU_FAULT_ADDR) |=>
      REG_RDATA_O[`ISU_SYS_ERR_BIT] == $past(STATUS_I.dsp_bus_system_fault_flag) &&
      REG_RDATA_O[`ISU_PACK_ERR_BIT] == $past(STATUS_I.dsp_bus_packing_fault_flag);
  endproperty
  a_bus_fault_read: assert property (p_bus_fault_read)
    else $error("dsp bus fault status read wrong");

  // Soft interrupt word holds only the four low bits
  property p_soft_read;
    REG_RD_I && (REG_ADDR_I == `ISU_SOFT_ADDR) |=>
      REG_RDATA_O == {28'h0, $past(STATUS_I.dsp_soft_irq_flag)};
  endproperty
  a_soft_read: assert property (p_soft_read)
    else $error("dsp soft interrupt status read wrong");

  // Event log word shows the full condition at its one bit
  property p_log_read;
    REG_RD_I && (REG_ADDR_I == `ISU_LOG_ADDR) |=>
      REG_RDATA_O == ({31'h0, $past(STATUS_I.event_log_full_flag)} << `ISU_LOG_FULL_BIT);
  endproperty
  a_log_read: assert property (p_log_read)
    else $error("event log full status read wrong");

  // Odd bits of the pin word never carry a level
  property p_pin_even;
    REG_RD_I && (REG_ADDR_I == `ISU_PIN_ADDR) |=>
      (REG_RDATA_O & 32'haaaa_ffff) == 32'h0000_0000;
  endproperty
  a_pin_even: assert property (p_pin_even)
    else $error("pin word has bits off the even positions");

  // Pin 4, when not a plain input, reads 0 whatever its level
  property p_pin_noinput;
    REG_RD_I && (REG_ADDR_I == `ISU_PIN_ADDR) && !GPIO_IS_INPUT_I[4] |=>
      !REG_RDATA_O[`ISU_PIN_LSB+8];
  endproperty
  a_pin_noinput: assert property (p_pin_noinput)
    else $error("non-input pin reported a level");

  // Trigger-type write lands in full on the next cycle
  property p_trig_write;
    REG_WR_I && (REG_ADDR_I == `ISU_TRIG_ADDR) |=>
      s_q.trig == $past(REG_WDATA_I[31:`ISU_TRIG_LSB]);
  endproperty
  a_trig_write: assert property (p_trig_write)
    else $error("trigger type write not stored");

  // A fresh unmasked event raises the request one cycle later
  property p_unmasked_raise;
    (|(set_v & ~s_q.event_mask_bit)) && !wr_mask |=> IRQ_O;
  endproperty
  a_unmasked_raise: assert property (p_unmasked_raise)
    else $error("unmasked event did not raise the request");

  c_irq_rise:   cover property ($rose(IRQ_O));
  c_mask_write: cover property (wr_mask ##1 IRQ_O);
  c_flag_clear: cover property (wr_flag ##1 $fell(IRQ_O));
  c_pin_edge:   cover property (s_q.trig[0] && $rose(s_q.lvl[0]));
endmodule

// ==== bench/isu_host_mdl.sv ====
// Host-side model that counts interrupt requests it is asked to service
module isu_host_mdl (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_i,
  output logic      [7:0] irq_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_q;
  // Host sees a level; only a fresh rise is a new service request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q     <= 1'b0;
      irq_cnt_o <= 8'h00;
    end else begin
      irq_q <= irq_i;
      if (irq_i && !irq_q) begin
        irq_cnt_o <= irq_cnt_o + 8'h01;
      end
    end
  end
endmodule

// ==== bench/isu_tb.sv ====
// Self-checking bench for the interrupt status/mask unit
`include "isu_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isu_pkg::*;
  logic               mclk;
  logic               rst;
  logic               wr;
  logic               rd;
  logic [`ISU_AW-1:0] addr;
  logic [31:0]        wdata;
  logic [31:0]        rdata;
  isu_status_s        sts;
  isu_bank_t          evt;
  logic [7:0]         pins;
  logic [7:0]         is_in;
  logic [7:0]         irq_cnt;
  logic               irq;
  int                 err_total;
  int                 compares;
  localparam logic [17:0] FLAG10 = `ISU_FLAG_BASE + 18'h0_0028;
  localparam logic [17:0] ADR [5] = '{`ISU_SIG_DET_ADDR, `ISU_FREQ_ADDR, `ISU_FAULT_ADDR,
                                      `ISU_SOFT_ADDR, `ISU_LOG_ADDR};
  // Expected status words for the alternating and the inverted pattern
  localparam logic [31:0] EXP [2][5] = '{
    '{32'h0044_0000, 32'h0000_0100, 32'h0005_0000, 32'h0000_000a, 32'h0000_0000},
    '{32'h0111_0000, 32'h0000_0001, 32'h0012_0000, 32'h0000_0005, 32'h0001_0000}};

  isu_top i_isu_top (.MCLK_I(mclk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .STATUS_I(sts),
    .EVT_SRC_I(evt), .GPIO_PIN_I(pins), .GPIO_IS_INPUT_I(is_in), .IRQ_O(irq));
  isu_host_mdl i_isu_host_mdl (.clk_i(mclk), .rst_i(rst), .irq_i(irq), .irq_cnt_o(irq_cnt));

  // Free-running system clock
  always #10 mclk = ~mclk;

  task automatic test_done();
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes last one cycle; each access waits a falling edge first
  task automatic wr32(input logic [17:0] a, input logic [31:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask

  // Read data holds until the next read, so sample a full cycle late
  task automatic rd32(input logic [17:0] a, input logic [31:0] exp);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    @(negedge mclk);
    chk(rdata, exp);
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 8) begin
      @(negedge mclk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, exp});
    // Only a wait that ran out without the level ends the run
    if (irq !== exp) begin
      test_done();
    end
  endtask

  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    sts = '0;
    evt = '0;
    pins = 8'h00;
    is_in = 8'h00;
    err_total = 0;
    compares = 0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    // Boot event first: it is the only one unmasked out of reset
    evt[1][3] = 1'b1;
    wait_irq(1'b1);
    rd32(`ISU_FLAG_BASE + 18'h0_0004, 32'h0000_0008);
    wr32(`ISU_FLAG_BASE + 18'h0_0004, 32'h0000_0008);
    wait_irq(1'b0);
    rd32(`ISU_FLAG_BASE + 18'h0_0004, 32'h0000_0000);
    for (int w = 0; w < 22; w++) begin
      rd32(`ISU_MASK_BASE + 18'(4 * w), (w == 1) ? 32'hffff_fff7 : `ISU_MASK_RESET);
    end
    rd32(`ISU_TRIG_ADDR, 32'h0000_0000);
    rd32(18'h1_8200, 32'h0000_0000);
    // Live status words, each pattern then its inverse
    for (int a = 0; a < 2; a++) begin
      sts = '{a[0], ~a[0], a[0], ~a[0], a[0], ~a[0], a[0], a[0], ~a[0], a[0], ~a[0],
              a[0] ? 4'h5 : 4'ha, a[0]};
      wr32(ADR[a * 3], 32'hffff_ffff);
      for (int i = 0; i < 5; i++) begin
        rd32(ADR[i], EXP[a][i]);
      end
    end
    // Masked event latches silently, then unmasking raises the request
    evt[0][5] = 1'b1;
    repeat (3) @(negedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    evt[0][5] = 1'b0;
    wr32(`ISU_MASK_BASE, 32'hffff_ffdf);
    wait_irq(1'b1);
    rd32(ADR[0], EXP[1][0]);
    rd32(`ISU_FLAG_BASE, 32'h0000_0020);
    wr32(`ISU_MASK_BASE, `ISU_MASK_RESET);
    wait_irq(1'b0);
    chk({24'h0, irq_cnt}, 32'h0000_0002);
    // Pin levels, only plain inputs report
    is_in = 8'h0f;
    pins = 8'h5a;
    repeat (6) @(negedge mclk);
    rd32(`ISU_PIN_ADDR, 32'h0044_0000);
    is_in = 8'hff;
    rd32(`ISU_PIN_ADDR, 32'h1144_0000);
    // Trigger types: GPIO1 rise edge-triggered, all else level-triggered
    wr32(`ISU_TRIG_ADDR, 32'ha5a5_ffff);
    rd32(`ISU_TRIG_ADDR, 32'ha5a5_0000);
    wr32(`ISU_TRIG_ADDR, 32'h0001_0000);
    wr32(FLAG10, 32'hffff_ffff);
    rd32(FLAG10, 32'h9966_0000);
    pins = 8'h5b;
    repeat (6) @(negedge mclk);
    rd32(FLAG10, 32'h9967_0000);
    wr32(FLAG10, 32'hffff_ffff);
    rd32(FLAG10, 32'h9964_0000);
    // GPIO1 fall edge-triggered, its rise now level-triggered
    wr32(`ISU_TRIG_ADDR, 32'h0002_0000);
    wr32(FLAG10, 32'hffff_ffff);
    rd32(FLAG10, 32'h9965_0000);
    pins = 8'h5a;
    repeat (6) @(negedge mclk);
    rd32(FLAG10, 32'h9967_0000);
    wr32(FLAG10, 32'hffff_ffff);
    rd32(FLAG10, 32'h9964_0000);
    test_done();
  end
endmodule
